// ==== bms_map.svh ====
`ifndef BMS_MAP_SVH
`define BMS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BMS_REG_STATUS 8'h00
`define BMS_REG_SELECT 8'h04
`define BMS_REG_CTRL 8'h08

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BMS_ST_STRAP_LSB 0
`define BMS_ST_VALID_BIT 4
`define BMS_ST_FUSE_BIT 5
`define BMS_ST_ERR_BIT 6
`define BMS_ST_RECOV_BIT 7
`define BMS_ST_LPB_BIT 8
`define BMS_SEL_DEV_LSB 0
`define BMS_SEL_HOST_BIT 3
`define BMS_SEL_WIDTH_LSB 4
`define BMS_CTRL_FAIL_BIT 0
`define BMS_CTRL_SERIAL_PERIPH_TWO_BIT 1

// ----------------------------------------------------------------------
// Strap, fuse and pin function encodings
// ----------------------------------------------------------------------
`define BMS_MODE_FUSE 3'h0
`define BMS_MODE_DL 3'h1
`define BMS_MODE_EMMC 3'h2
`define BMS_MODE_SD 3'h3
`define BMS_MODE_NOR 3'h4
`define BMS_MODE_NAND 3'h5
`define BMS_WIDTH_1 2'h0
`define BMS_WIDTH_4 2'h1
`define BMS_WIDTH_8 2'h2
`define BMS_PIN_FUNC_ZERO 2'h0
`define BMS_PIN_FUNC_TWO 2'h2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define BMS_CTRL_RESET 2'h0
`define BMS_SETTLE_NS 100
`define BMS_CLK_PERIOD_PS 5000

`endif

// ==== bms_pkg.sv ====
package bms_pkg;

  typedef enum logic [2:0] {
    DEV_NONE, DEV_USB, DEV_EMMC, DEV_SD, DEV_NOR, DEV_NAND, DEV_SERIAL_PERIPH_ONE, DEV_SERIAL_PERIPH_TWO
  } bms_dev_type;

  typedef enum logic [2:0] {
    ST_SETTLE, ST_PRIMARY, ST_RECOVERY, ST_DOWNLOAD, ST_HALT
  } bms_state_type;

endpackage : bms_pkg

// ==== bms_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module bms_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_q,
  output logic stable
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;
  logic [W-1:0] stage3_reg;
  logic [1:0] fill_reg;

  // The first stage feeds only the second one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Reset values are not pin samples, so agreement only counts once three
  // real samples have entered the chain; otherwise a low strap would get a
  // shorter settle window than a high one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_reg <= 2'h0;
    end else if (fill_reg != 2'h3) begin
      fill_reg <= fill_reg + 2'h1;
    end
  end

  assign sync_q = stage3_reg;
  assign stable = (fill_reg == 2'h3) && (stage2_reg == stage3_reg);

endmodule : bms_sync

`default_nettype wire

// ==== bms_top.sv ====
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bms_map.svh"

module bms_top #(
  parameter int STRAP_W = 4,
  parameter int GROUPS = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [STRAP_W-1:0] strap_pin,
  input wire logic fuse_override,
  input wire logic [2:0] fuse_primary_dev,
  input wire logic fuse_sd_host_two,
  input wire logic [1:0] fuse_flash_width,
  input wire logic fuse_low_power_boot,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic cfg_valid,
  output logic pin_strap_mode,
  output logic [2:0] active_dev,
  output logic sd_host_two,
  output logic [1:0] flash_width,
  output logic boot_error,
  output logic usb_dl_en,
  output logic realtime_core_rst_n,
  output logic app_core_rst_n,
  output logic [GROUPS-1:0] pin_group_en,
  output logic [2*GROUPS-1:0] pin_group_func
);

  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  // A least settle time, so the cycle count rounds up.
  localparam int SETTLE_CYC_RAW =
    (`BMS_SETTLE_NS * 1000 + `BMS_CLK_PERIOD_PS - 1) / `BMS_CLK_PERIOD_PS;
  localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYC - 1);

  // ----------------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------------
  logic [STRAP_W-1:0] strap_sync;
  logic strap_stable;

  bms_sync #(
    .W(STRAP_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(strap_pin),
    .sync_q(strap_sync),
    .stable(strap_stable)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  bms_pkg::bms_state_type state_reg;
  bms_pkg::bms_state_type state_next;
  logic [7:0] settle_reg;
  logic [STRAP_W-1:0] strap_reg;
  logic valid_reg;
  logic fuse_used_reg;
  logic err_reg;
  logic lpb_reg;
  logic serial_periph_two_reg;
  logic host_two_reg;
  logic [1:0] width_reg;
  bms_pkg::bms_dev_type dev_reg;
  bms_pkg::bms_dev_type dev_next;
  logic host_two_next;
  logic [1:0] width_next;
  logic err_next;
  logic fuse_used_next;
  logic capture;
  logic fail_wr;
  logic [31:0] rdata_reg;

  assign capture = (state_reg == bms_pkg::ST_SETTLE) && strap_stable &&
                   (settle_reg == SETTLE_LAST);
  assign fail_wr = wr_en && (addr == `BMS_REG_CTRL) &&
                   wdata[`BMS_CTRL_FAIL_BIT];

  // ----------------------------------------------------------------------
  // Boot source decode
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] mode;
    mode = strap_sync[2:0];
    fuse_used_next = (mode == `BMS_MODE_FUSE) || fuse_override;
    if (fuse_used_next) begin
      mode = fuse_primary_dev;
    end
    dev_next = bms_pkg::DEV_NONE;
    host_two_next = 1'b0;
    err_next = 1'b0;
    case (mode)
      `BMS_MODE_DL: begin
        dev_next = bms_pkg::DEV_USB;
      end
      `BMS_MODE_EMMC: begin
        dev_next = bms_pkg::DEV_EMMC;
      end
      `BMS_MODE_SD: begin
        dev_next = bms_pkg::DEV_SD;
        host_two_next = fuse_used_next ? fuse_sd_host_two : 1'b1;
      end
      `BMS_MODE_NOR: begin
        dev_next = bms_pkg::DEV_NOR;
      end
      `BMS_MODE_NAND: begin
        dev_next = bms_pkg::DEV_NAND;
      end
      default: begin
        err_next = 1'b1;
      end
    endcase
    // flash width, invalid falls back to one bit
    width_next = (fuse_flash_width == 2'h3) ? `BMS_WIDTH_1 : fuse_flash_width;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bms_pkg::ST_SETTLE: begin
        if (capture) begin
          if (err_next) begin
            state_next = bms_pkg::ST_RECOVERY;
          end else if (dev_next == bms_pkg::DEV_USB) begin
            state_next = bms_pkg::ST_DOWNLOAD;
          end else begin
            state_next = bms_pkg::ST_PRIMARY;
          end
        end
      end
      bms_pkg::ST_PRIMARY: begin
        if (fail_wr) begin
          state_next = bms_pkg::ST_RECOVERY;
        end
      end
      bms_pkg::ST_RECOVERY: begin
        if (fail_wr) begin
          state_next = bms_pkg::ST_HALT;
        end
      end
      bms_pkg::ST_DOWNLOAD: begin
        state_next = bms_pkg::ST_DOWNLOAD;
      end
      bms_pkg::ST_HALT: begin
        state_next = bms_pkg::ST_HALT;
      end
      default: begin
        state_next = bms_pkg::ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= bms_pkg::ST_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_reg <= 8'h00;
    end else if (state_reg != bms_pkg::ST_SETTLE || !strap_stable) begin
      settle_reg <= 8'h00;
    end else if (settle_reg != SETTLE_LAST) begin
      settle_reg <= settle_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Latched configuration
  // ----------------------------------------------------------------------
  // latch straps once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_reg <= '0;
      valid_reg <= 1'b0;
      fuse_used_reg <= 1'b0;
      host_two_reg <= 1'b0;
      width_reg <= `BMS_WIDTH_1;
      lpb_reg <= 1'b0;
    end else if (capture) begin
      strap_reg <= strap_sync;
      valid_reg <= 1'b1;
      fuse_used_reg <= fuse_used_next;
      host_two_reg <= host_two_next;
      width_reg <= width_next;
      lpb_reg <= fuse_low_power_boot;
    end
  end

  // Software chooses the recovery port; it is only read on a primary boot failure, a strap error always takes port one.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_periph_two_reg <= 1'b0;
    end else if (wr_en && addr == `BMS_REG_CTRL) begin
      serial_periph_two_reg <= wdata[`BMS_CTRL_SERIAL_PERIPH_TWO_BIT];
    end
  end

  // recovery only on a serial peripheral port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_reg <= bms_pkg::DEV_NONE;
      err_reg <= 1'b0;
    end else if (capture) begin
      dev_reg <= err_next ? bms_pkg::DEV_SERIAL_PERIPH_ONE : dev_next;
      err_reg <= err_next;
    end else if (state_reg == bms_pkg::ST_PRIMARY && fail_wr) begin
      dev_reg <= serial_periph_two_reg ? bms_pkg::DEV_SERIAL_PERIPH_TWO : bms_pkg::DEV_SERIAL_PERIPH_ONE;
    end else if (state_reg == bms_pkg::ST_RECOVERY && fail_wr) begin
      dev_reg <= bms_pkg::DEV_NONE;
      err_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Core reset release
  // ----------------------------------------------------------------------
  logic rt_rst_n_reg;
  logic app_rst_n_reg;

  // low power boot keeps application cores held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rt_rst_n_reg <= 1'b0;
      app_rst_n_reg <= 1'b0;
    end else if (capture) begin
      rt_rst_n_reg <= 1'b1;
      app_rst_n_reg <= !fuse_low_power_boot;
    end
  end

  // ----------------------------------------------------------------------
  // Pin routing
  // ----------------------------------------------------------------------
  // Group order: flash, SD one, SD one reset, SD two, port one, port two.
  logic [GROUPS-1:0] grp_want;
  logic [GROUPS-1:0] grp_en_reg;
  logic [2*GROUPS-1:0] grp_func_reg;
  logic strap_mode_reg;
  logic usb_reg;

  always_comb begin
    grp_want = '0;
    grp_want[0] = (dev_reg == bms_pkg::DEV_NOR) ||
                  (dev_reg == bms_pkg::DEV_NAND);
    grp_want[1] = (dev_reg == bms_pkg::DEV_EMMC) ||
                  (dev_reg == bms_pkg::DEV_SD && !host_two_reg);
    grp_want[2] = (dev_reg == bms_pkg::DEV_EMMC);
    grp_want[3] = (dev_reg == bms_pkg::DEV_SD && host_two_reg);
    grp_want[4] = (dev_reg == bms_pkg::DEV_SERIAL_PERIPH_ONE);
    grp_want[5] = (dev_reg == bms_pkg::DEV_SERIAL_PERIPH_TWO);
  end

  for (genvar g = 0; g < GROUPS; g++) begin : g_pins
    localparam logic [1:0] FUNC =
      (g == 2 || g >= 4) ? `BMS_PIN_FUNC_TWO : `BMS_PIN_FUNC_ZERO;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        grp_en_reg[g] <= 1'b0;
        grp_func_reg[2*g +: 2] <= `BMS_PIN_FUNC_ZERO;
      end else begin
        grp_en_reg[g] <= grp_want[g];
        grp_func_reg[2*g +: 2] <= grp_want[g] ? FUNC : `BMS_PIN_FUNC_ZERO;
      end
    end
  end

  // pins serve the straps until capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_mode_reg <= 1'b1;
      usb_reg <= 1'b0;
    end else begin
      strap_mode_reg <= (state_reg == bms_pkg::ST_SETTLE) && !capture;
      usb_reg <= (dev_reg == bms_pkg::DEV_USB);
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= 32'h0000_0000;
      if (rd_en) begin
        case (addr)
          `BMS_REG_STATUS: begin
            rdata_reg[`BMS_ST_STRAP_LSB +: STRAP_W] <= strap_reg;
            rdata_reg[`BMS_ST_VALID_BIT] <= valid_reg;
            rdata_reg[`BMS_ST_FUSE_BIT] <= fuse_used_reg;
            rdata_reg[`BMS_ST_ERR_BIT] <= err_reg;
            rdata_reg[`BMS_ST_RECOV_BIT] <=
              (state_reg == bms_pkg::ST_RECOVERY);
            rdata_reg[`BMS_ST_LPB_BIT] <= lpb_reg;
          end
          `BMS_REG_SELECT: begin
            rdata_reg[`BMS_SEL_DEV_LSB +: 3] <= dev_reg;
            rdata_reg[`BMS_SEL_HOST_BIT] <= host_two_reg;
            rdata_reg[`BMS_SEL_WIDTH_LSB +: 2] <= width_reg;
          end
          `BMS_REG_CTRL: begin
            rdata_reg[`BMS_CTRL_SERIAL_PERIPH_TWO_BIT] <= serial_periph_two_reg;
          end
          default: begin
            rdata_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign rdata = rdata_reg;
  assign cfg_valid = valid_reg;
  assign pin_strap_mode = strap_mode_reg;
  assign active_dev = dev_reg;
  assign sd_host_two = host_two_reg;
  assign flash_width = width_reg;
  assign boot_error = err_reg;
  assign usb_dl_en = usb_reg;
  assign realtime_core_rst_n = rt_rst_n_reg;
  assign app_core_rst_n = app_rst_n_reg;
  assign pin_group_en = grp_en_reg;
  assign pin_group_func = grp_func_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  strap_capture_a: assert property (
    capture |=> strap_reg == $past(strap_sync)
  ) else $error("strap value not latched at capture");

  reserved_code_a: assert property (
    capture && strap_sync[2:1] == 2'b11 && !fuse_override |=> err_reg
  ) else $error("reserved strap code not flagged");

  settle_first_a: assert property (
    $rose(valid_reg) |-> $past(settle_reg) == SETTLE_LAST
  ) else $error("capture before settle window");

  latch_hold_a: assert property (
    valid_reg |=> $stable(strap_reg) && valid_reg
  ) else $error("latched straps changed");

  fuse_source_a: assert property (
    capture && fuse_used_next && fuse_primary_dev == `BMS_MODE_NOR
    |=> dev_reg == bms_pkg::DEV_NOR
  ) else $error("fuse primary device ignored");

  recovery_port_a: assert property (
    state_reg == bms_pkg::ST_RECOVERY |-> dev_reg == bms_pkg::DEV_SERIAL_PERIPH_ONE ||
      dev_reg == bms_pkg::DEV_SERIAL_PERIPH_TWO
  ) else $error("recovery on a non serial port");

  lpb_release_a: assert property (
    $rose(rt_rst_n_reg) |-> app_rst_n_reg == !lpb_reg
  ) else $error("low power boot released application cores");

  emmc_host_a: assert property (
    dev_reg == bms_pkg::DEV_EMMC |-> !host_two_reg
  ) else $error("eMMC on host two");

  spi_func_a: assert property (
    dev_reg == bms_pkg::DEV_SERIAL_PERIPH_TWO |=> grp_en_reg[5] &&
      grp_func_reg[11:10] == `BMS_PIN_FUNC_TWO
  ) else $error("port two pins not on function two");

  usb_nomux_a: assert property (
    dev_reg == bms_pkg::DEV_USB |=> usb_reg && grp_en_reg == '0
  ) else $error("download enabled pin groups");

  width_ok_a: assert property (
    width_reg != 2'h3
  ) else $error("flash width out of range");

  boot_nor_c: cover property (capture ##1 dev_reg == bms_pkg::DEV_NOR);
  boot_recov_c: cover property (
    state_reg == bms_pkg::ST_PRIMARY ##1 state_reg == bms_pkg::ST_RECOVERY);
  boot_dl_c: cover property (state_reg == bms_pkg::ST_DOWNLOAD);
  boot_lpb_c: cover property (rt_rst_n_reg && !app_rst_n_reg);

endmodule : bms_top

`default_nettype wire

// ==== bms_board_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Board straps: pull levels during reset, shared use afterwards
// ----------------------------------------------------------------------
module bms_board_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] strap_cfg,
  input wire logic func_use,
  output logic [3:0] strap_pin
);
  logic toggle_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= ~toggle_reg;
    end
  end

  // outputs quiet in reset
  // Shared functions stay off the pins while reset is low, so only the
  // pull levels are seen; afterwards, while func_use is set, the pins change on every cycle.
  assign strap_pin = (rst_n && func_use) ?
                     (strap_cfg ^ (toggle_reg ? 4'hA : 4'h5)) : strap_cfg;
endmodule : bms_board_model

`default_nettype wire

// ==== bms_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bms_map.svh"

module bms_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] strap_cfg = 4'h0;
  logic func_use = 1'b0;
  logic [3:0] strap_pin;
  logic fuse_override = 1'b0;
  logic [2:0] fuse_primary_dev = 3'h0;
  logic fuse_sd_host_two = 1'b0;
  logic [1:0] fuse_flash_width = 2'h0;
  logic fuse_low_power_boot = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rdata;
  logic cfg_valid, pin_strap_mode, sd_host_two, boot_error, usb_dl_en;
  logic realtime_core_rst_n, app_core_rst_n;
  logic [2:0] active_dev;
  logic [1:0] flash_width;
  logic [5:0] pin_group_en;
  logic [11:0] pin_group_func;
  int n_errors = 0;
  int total_checks = 0;

  always #2.5 clk = ~clk;

  bms_board_model i_bms_board_model (.clk(clk), .rst_n(rst_n),
    .strap_cfg(strap_cfg), .func_use(func_use), .strap_pin(strap_pin));

  bms_top i_bms_top (.clk(clk), .rst_n(rst_n), .strap_pin(strap_pin),
    .fuse_override(fuse_override), .fuse_primary_dev(fuse_primary_dev),
    .fuse_sd_host_two(fuse_sd_host_two), .fuse_flash_width(fuse_flash_width),
    .fuse_low_power_boot(fuse_low_power_boot), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cfg_valid(cfg_valid),
    .pin_strap_mode(pin_strap_mode), .active_dev(active_dev),
    .sd_host_two(sd_host_two), .flash_width(flash_width),
    .boot_error(boot_error), .usb_dl_en(usb_dl_en),
    .realtime_core_rst_n(realtime_core_rst_n),
    .app_core_rst_n(app_core_rst_n), .pin_group_en(pin_group_en),
    .pin_group_func(pin_group_func));

  // ----------------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk_port(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD port t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_port

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD reg t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : reg_rd

  // ----------------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------------
  function automatic logic [2:0] dev_of(input logic [2:0] c);
    case (c)
      `BMS_MODE_DL: dev_of = bms_pkg::DEV_USB;
      `BMS_MODE_EMMC: dev_of = bms_pkg::DEV_EMMC;
      `BMS_MODE_SD: dev_of = bms_pkg::DEV_SD;
      `BMS_MODE_NOR: dev_of = bms_pkg::DEV_NOR;
      `BMS_MODE_NAND: dev_of = bms_pkg::DEV_NAND;
      default: dev_of = bms_pkg::DEV_SERIAL_PERIPH_ONE;
    endcase
  endfunction : dev_of

  function automatic logic [5:0] en_of(input logic [2:0] d, input logic h2);
    case (d)
      bms_pkg::DEV_NOR, bms_pkg::DEV_NAND: en_of = 6'h01;
      bms_pkg::DEV_EMMC: en_of = 6'h06;
      bms_pkg::DEV_SD: en_of = h2 ? 6'h08 : 6'h02;
      bms_pkg::DEV_SERIAL_PERIPH_ONE: en_of = 6'h10;
      bms_pkg::DEV_SERIAL_PERIPH_TWO: en_of = 6'h20;
      default: en_of = 6'h00;
    endcase
  endfunction : en_of

  function automatic logic [11:0] func_of(input logic [5:0] en);
    func_of = 12'h000;
    for (int g = 0; g < 6; g++) begin
      if (en[g]) begin
        func_of[2*g +: 2] = (g == 2 || g >= 4) ? `BMS_PIN_FUNC_TWO :
                            `BMS_PIN_FUNC_ZERO;
      end
    end
  endfunction : func_of

  // ----------------------------------------------------------------------
  // One boot: straps and fuses, capture, status, failure path
  // ----------------------------------------------------------------------
  task automatic boot_case(input logic [3:0] s, input logic ov,
                           input logic [2:0] fd, input logic [3:0] ex);
    logic fz, err, h2, p2;
    logic [2:0] dev;
    logic [31:0] st, rd;
    int n;
    fz = ov || (s[2:0] == `BMS_MODE_FUSE);
    dev = dev_of(fz ? fd : s[2:0]);
    err = (dev == bms_pkg::DEV_SERIAL_PERIPH_ONE);
    h2 = fz ? ex[2] : 1'b1;
    st = {23'h0, ex[3], err, err, fz, 1'b1, s};
    @(posedge clk);
    rst_n <= 1'b0;
    func_use <= 1'b0;
    strap_cfg <= s;
    fuse_override <= ov;
    fuse_primary_dev <= fd;
    {fuse_low_power_boot, fuse_sd_host_two, fuse_flash_width} <= ex;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk_port({pin_strap_mode, cfg_valid}, 12'h2);
    n = 0;
    while (cfg_valid !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    // Counting starts at the second edge after release: three sync samples
    // and the settle window put the capture on the edge after that span.
    chk_port(12'(n), 12'(`BMS_SETTLE_NS * 1000 / `BMS_CLK_PERIOD_PS + 2));
    chk_port({pin_strap_mode, cfg_valid}, 12'h1);
    chk_port(active_dev, dev);
    chk_port({realtime_core_rst_n, app_core_rst_n}, {1'b1, !ex[3]});
    repeat (2) @(posedge clk);
    #1 chk_port(usb_dl_en, dev == bms_pkg::DEV_USB);
    chk_port(pin_group_en, en_of(dev, h2));
    chk_port(pin_group_func, func_of(en_of(dev, h2)));
    if (dev == bms_pkg::DEV_SD || dev == bms_pkg::DEV_EMMC) begin
      chk_port(sd_host_two, dev == bms_pkg::DEV_SD && h2);
    end
    if (dev == bms_pkg::DEV_NOR || dev == bms_pkg::DEV_NAND) begin
      chk_port(flash_width, (ex[1:0] == 2'h3) ? 2'h0 : ex[1:0]);
    end
    func_use <= 1'b1;
    repeat (10) @(posedge clk);
    reg_rd(`BMS_REG_STATUS, rd);
    chk_reg(rd, st);
    reg_wr(`BMS_REG_STATUS, 32'hFFFF_FFFF);
    reg_rd(`BMS_REG_STATUS, rd);
    chk_reg(rd, st);
    reg_rd(`BMS_REG_SELECT, rd);
    chk_reg(rd & 32'h7, dev);
    reg_rd(8'h0C, rd);
    chk_reg(rd, 32'h0);
    if (dev == bms_pkg::DEV_USB) begin
      reg_wr(`BMS_REG_CTRL, 32'h1);
      @(posedge clk);
      #1 chk_port(active_dev, bms_pkg::DEV_USB);
    end else begin
      if (!err) begin
        p2 = 1'($urandom);
        reg_wr(`BMS_REG_CTRL, {30'h0, p2, 1'b0});
        reg_rd(`BMS_REG_CTRL, rd);
        chk_reg(rd, {30'h0, p2, 1'b0});
        reg_wr(`BMS_REG_CTRL, {30'h0, p2, 1'b1});
        #1 chk_port(active_dev, p2 ? bms_pkg::DEV_SERIAL_PERIPH_TWO : bms_pkg::DEV_SERIAL_PERIPH_ONE);
        @(posedge clk);
        #1 chk_port(pin_group_en, p2 ? 6'h20 : 6'h10);
        chk_port(pin_group_func, p2 ? 12'h800 : 12'h200);
      end
      reg_wr(`BMS_REG_CTRL, 32'h1);
      @(posedge clk);
      #1 chk_port({active_dev, boot_error}, {bms_pkg::DEV_NONE, 1'b1});
    end
    $display("boot done strap=%h ovr=%b fuse=%h dev=%h", s, ov, fd, dev);
  endtask : boot_case

  task automatic finish_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    finish_test();
  end

  initial begin
    void'($urandom(97));
    for (int c = 0; c < 8; c++) begin
      boot_case({c[1], c[2:0]}, 1'b0, 3'h3, 4'h6);
    end
    for (int c = 0; c < 8; c++) begin
      boot_case(4'($urandom), 1'b1, c[2:0], 4'($urandom));
    end
    for (int c = 0; c < 6; c++) begin
      boot_case(4'($urandom), 1'($urandom), 3'($urandom), 4'($urandom));
    end
    finish_test();
  end
endmodule : bms_top_tb

`default_nettype wire
